// ==== hdl/ilc_io_line_controller.sv ====
// What this block does
// RULE_01: Thirty-two lines, each owning one bit of every per-line register.
// RULE_02: Pull-up on/off writes update pull-up state; zero means pull-up on.
// RULE_03: Pull-down on/off writes update pull-down state; zero means pull-down on.
// RULE_04: Enabling one pull while the other is on is discarded for that line.
// RULE_05: Pull-up acts whatever the line's ownership or other configuration.
// RULE_06: Reset turns all pull-ups on (state zero) and all pull-downs off.
// RULE_07: Owner writes set/clear owner state; one is controller, zero peripheral.
// RULE_08: Lines without peripherals ignore owner writes and read owner one.
// RULE_09: Owner state reset value is a per-product parameter.
// RULE_10: Select bits 00 choose A, lo=1 hi=0 B, lo=0 hi=1 C.
// RULE_11: Select bits both one choose peripheral D.
// RULE_12: Selection steers outputs only; peripheral inputs always see the pin.
// RULE_13: Select writes act regardless of ownership; handover also needs owner write.
// RULE_14: Both select registers reset to zero, selecting peripheral A.
// RULE_15: Peripheral-owned line takes drive enable and level from the peripheral.
// RULE_16: Drive on/off writes set/clear drive state; one means controller drives.
// RULE_17: Level set/clear writes set/clear the level driven by the controller.
// RULE_18: Drive and level writes update state even while a peripheral owns.
// RULE_19: Direct level writes touch only masked lines; mask has on/off writes.
// RULE_20: Direct write mask resets to zero.
// RULE_21: Open-drain lines drive only low, for either owner; on/off writes.
// RULE_22: Open-drain state resets to zero.
// RULE_23: In set/clear pairs a one acts on its line, a zero does nothing.
`default_nettype none

module ilc_io_line_controller
  import ilc_pkg::*;
#(
  parameter logic [31:0] OWNER_RESET = RST_OWNER_STATE,
  parameter logic [31:0] MUXED_LINES = RST_MUXED_LINES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ilc_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  input wire ilc_periph_type [ILC_PERIPHS-1:0] periph_drive,
  output logic [31:0] periph_pin_in,
  input wire logic [ILC_LINES-1:0] pin_in,
  output ilc_pad_type pad
);

  ilc_state_type state;
  ilc_state_type next_state;

  localparam ilc_state_type RESET_STATE = '{
    owner_state: OWNER_RESET | ~MUXED_LINES, // RULE_09
    drive_state: RST_DRIVE_STATE,
    level_state: RST_LEVEL_STATE,
    direct_write_mask: RST_DIRECT_WRITE_MASK, // RULE_20
    open_drain_state: RST_OPEN_DRAIN_STATE, // RULE_22
    pullup_state: RST_PULLUP_STATE, // RULE_06
    pulldown_state: RST_PULLDOWN_STATE, // RULE_06
    periph_select_lo: RST_PERIPH_SELECT, // RULE_14
    periph_select_hi: RST_PERIPH_SELECT, // RULE_14
    pin_sync1: RST_ZERO,
    pin_sync2: RST_ZERO,
    rdata: RST_ZERO,
    pad: '{out: RST_ZERO, oe: RST_ZERO, pullup_en: ~RST_PULLUP_STATE,
      pulldown_en: ~RST_PULLDOWN_STATE}
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes, read mux and pad drive.

  always_comb
  begin
    logic [1:0] sel;
    logic own;
    logic en;
    logic lvl;
    logic [31:0] wd;
    sel = 2'b00;
    own = 1'b0;
    en = 1'b0;
    lvl = 1'b0;
    wd = bus_req.wdata;
    next_state = state;
    next_state.rdata = RST_ZERO;
    next_state.pin_sync1 = pin_in;
    next_state.pin_sync2 = state.pin_sync1;

    if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADDR_OWNER_CTRL_SET_WR:
          next_state.owner_state = state.owner_state | (wd & MUXED_LINES); // RULE_07 RULE_08
        ADDR_OWNER_PERIPH_SET_WR:
          next_state.owner_state = state.owner_state & ~(wd & MUXED_LINES); // RULE_07 RULE_08
        ADDR_DRIVE_ON_WR:
          next_state.drive_state = state.drive_state | wd; // RULE_16 RULE_18 RULE_23
        ADDR_DRIVE_OFF_WR:
          next_state.drive_state = state.drive_state & ~wd; // RULE_16 RULE_18 RULE_23
        ADDR_LEVEL_SET_WR:
          next_state.level_state = state.level_state | wd; // RULE_17 RULE_18 RULE_23
        ADDR_LEVEL_CLEAR_WR:
          next_state.level_state = state.level_state & ~wd; // RULE_17 RULE_18 RULE_23
        ADDR_LEVEL_STATE:
          next_state.level_state = (state.level_state & ~state.direct_write_mask)
            | (wd & state.direct_write_mask); // RULE_19
        ADDR_DIRECT_WRITE_ON_WR:
          next_state.direct_write_mask = state.direct_write_mask | wd; // RULE_19 RULE_23
        ADDR_DIRECT_WRITE_OFF_WR:
          next_state.direct_write_mask = state.direct_write_mask & ~wd; // RULE_19 RULE_23
        ADDR_OPEN_DRAIN_ON_WR:
          next_state.open_drain_state = state.open_drain_state | wd; // RULE_21 RULE_23
        ADDR_OPEN_DRAIN_OFF_WR:
          next_state.open_drain_state = state.open_drain_state & ~wd; // RULE_21 RULE_23
        ADDR_PULLUP_OFF_WR:
          next_state.pullup_state = state.pullup_state | wd; // RULE_02 RULE_23
        ADDR_PULLUP_ON_WR:
          // A pull-up may only come on where the pull-down is already off.
          next_state.pullup_state = state.pullup_state
            & ~(wd & state.pulldown_state); // RULE_02 RULE_04 RULE_23
        ADDR_PULLDOWN_OFF_WR:
          next_state.pulldown_state = state.pulldown_state | wd; // RULE_03 RULE_23
        ADDR_PULLDOWN_ON_WR:
          next_state.pulldown_state = state.pulldown_state
            & ~(wd & state.pullup_state); // RULE_03 RULE_04 RULE_23
        ADDR_PERIPH_SELECT_LO:
          next_state.periph_select_lo = wd; // RULE_13
        ADDR_PERIPH_SELECT_HI:
          next_state.periph_select_hi = wd; // RULE_13
        default:
          next_state.rdata = RST_ZERO;
      endcase
    end

    if (bus_req.rd)
    begin
      case (bus_req.addr)
        ADDR_OWNER_STATE: next_state.rdata = state.owner_state | ~MUXED_LINES; // RULE_08
        ADDR_DRIVE_STATE: next_state.rdata = state.drive_state;
        ADDR_LEVEL_STATE: next_state.rdata = state.level_state;
        ADDR_DIRECT_WRITE_MASK: next_state.rdata = state.direct_write_mask;
        ADDR_OPEN_DRAIN_STATE: next_state.rdata = state.open_drain_state;
        ADDR_PULLUP_STATE: next_state.rdata = state.pullup_state;
        ADDR_PULLDOWN_STATE: next_state.rdata = state.pulldown_state;
        ADDR_PERIPH_SELECT_LO: next_state.rdata = state.periph_select_lo;
        ADDR_PERIPH_SELECT_HI: next_state.rdata = state.periph_select_hi;
        default: next_state.rdata = RST_ZERO;
      endcase
    end

    // Pulls follow their state bits alone, whoever owns the line.
    next_state.pad.pullup_en = ~next_state.pullup_state; // RULE_05
    next_state.pad.pulldown_en = ~next_state.pulldown_state; // RULE_03

    for (int i = 0; i < ILC_LINES; i++) // RULE_01
    begin
      sel = {next_state.periph_select_hi[i], next_state.periph_select_lo[i]}; // RULE_10 RULE_11
      own = next_state.owner_state[i];
      en = own ? next_state.drive_state[i] : periph_drive[sel].oe[i]; // RULE_15 RULE_16
      lvl = own ? next_state.level_state[i] : periph_drive[sel].out[i]; // RULE_15 RULE_17
      if (next_state.open_drain_state[i])
      begin
        next_state.pad.oe[i] = en & ~lvl; // RULE_21
        next_state.pad.out[i] = 1'b0; // RULE_21
      end
      else
      begin
        next_state.pad.oe[i] = en;
        next_state.pad.out[i] = lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= RESET_STATE;
    else
      state <= next_state;
  end

  assign bus_rdata = state.rdata;
  assign periph_pin_in = state.pin_sync2; // RULE_12
  assign pad = state.pad;

endmodule

`default_nettype wire

// ==== hdl/ilc_pkg.sv ====
`default_nettype none

package ilc_pkg;

  localparam int ILC_LINES = 32;
  localparam int ILC_PERIPHS = 4;
  localparam int ILC_ADDR_W = 8;

  // Register byte addresses.
  localparam logic [7:0] ADDR_OWNER_CTRL_SET_WR = 8'h00;
  localparam logic [7:0] ADDR_OWNER_PERIPH_SET_WR = 8'h04;
  localparam logic [7:0] ADDR_OWNER_STATE = 8'h08;
  localparam logic [7:0] ADDR_DRIVE_ON_WR = 8'h10;
  localparam logic [7:0] ADDR_DRIVE_OFF_WR = 8'h14;
  localparam logic [7:0] ADDR_DRIVE_STATE = 8'h18;
  localparam logic [7:0] ADDR_LEVEL_SET_WR = 8'h30;
  localparam logic [7:0] ADDR_LEVEL_CLEAR_WR = 8'h34;
  localparam logic [7:0] ADDR_LEVEL_STATE = 8'h38;
  localparam logic [7:0] ADDR_OPEN_DRAIN_ON_WR = 8'h50;
  localparam logic [7:0] ADDR_OPEN_DRAIN_OFF_WR = 8'h54;
  localparam logic [7:0] ADDR_OPEN_DRAIN_STATE = 8'h58;
  localparam logic [7:0] ADDR_PULLUP_OFF_WR = 8'h60;
  localparam logic [7:0] ADDR_PULLUP_ON_WR = 8'h64;
  localparam logic [7:0] ADDR_PULLUP_STATE = 8'h68;
  localparam logic [7:0] ADDR_PERIPH_SELECT_LO = 8'h70;
  localparam logic [7:0] ADDR_PERIPH_SELECT_HI = 8'h74;
  localparam logic [7:0] ADDR_PULLDOWN_OFF_WR = 8'h90;
  localparam logic [7:0] ADDR_PULLDOWN_ON_WR = 8'h94;
  localparam logic [7:0] ADDR_PULLDOWN_STATE = 8'h98;
  localparam logic [7:0] ADDR_DIRECT_WRITE_ON_WR = 8'hA0;
  localparam logic [7:0] ADDR_DIRECT_WRITE_OFF_WR = 8'hA4;
  localparam logic [7:0] ADDR_DIRECT_WRITE_MASK = 8'hA8;

  // Values after reset.
  localparam logic [31:0] RST_OWNER_STATE = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_MUXED_LINES = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_PULLUP_STATE = 32'h0000_0000;
  localparam logic [31:0] RST_PULLDOWN_STATE = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_PERIPH_SELECT = 32'h0000_0000;
  localparam logic [31:0] RST_DRIVE_STATE = 32'h0000_0000;
  localparam logic [31:0] RST_LEVEL_STATE = 32'h0000_0000;
  localparam logic [31:0] RST_DIRECT_WRITE_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_OPEN_DRAIN_STATE = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ILC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ilc_bus_req_type;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } ilc_periph_type;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pullup_en;
    logic [31:0] pulldown_en;
  } ilc_pad_type;

  typedef struct packed {
    logic [31:0] owner_state;
    logic [31:0] drive_state;
    logic [31:0] level_state;
    logic [31:0] direct_write_mask;
    logic [31:0] open_drain_state;
    logic [31:0] pullup_state;
    logic [31:0] pulldown_state;
    logic [31:0] periph_select_lo;
    logic [31:0] periph_select_hi;
    logic [31:0] pin_sync1;
    logic [31:0] pin_sync2;
    logic [31:0] rdata;
    ilc_pad_type pad;
  } ilc_state_type;

endpackage

`default_nettype wire

// ==== test/ilc_io_line_controller_chk.sv ====
`default_nettype none

module ilc_io_line_controller_chk
  import ilc_pkg::*;
#(
  parameter logic [31:0] MUXED_LINES = RST_MUXED_LINES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ilc_bus_req_type bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic [31:0] periph_pin_in,
  input wire logic [ILC_LINES-1:0] pin_in,
  input wire ilc_pad_type pad
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rd_of(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence sel_wr_rd;
    bus_req.wr && bus_req.addr == ADDR_PERIPH_SELECT_LO ##1 rd_of(ADDR_PERIPH_SELECT_LO);
  endsequence
  rdata_idle_a: assert property (
    !bus_req.rd |=> bus_rdata == 32'h0000_0000) else $error("read data not idle zero");
  pull_excl_a: assert property (
    (pad.pullup_en & pad.pulldown_en) == 32'h0000_0000) else $error("both pulls on");
  reset_pull_a: assert property (
    $fell(rst) |-> pad.pullup_en == 32'hFFFF_FFFF && pad.pulldown_en == 32'h0000_0000)
    else $error("pull reset values wrong");
  pin_sync_a: assert property (
    !$past(rst) && !$past(rst, 2) |-> periph_pin_in == $past(pin_in, 2))
    else $error("peripheral input not pin level");
  owner_fixed_a: assert property (
    rd_of(ADDR_OWNER_STATE) |=> (bus_rdata & ~MUXED_LINES) == ~MUXED_LINES)
    else $error("unmuxed line not controller owned");
  pullup_rd_a: assert property (
    rd_of(ADDR_PULLUP_STATE) |=> bus_rdata == ~$past(pad.pullup_en))
    else $error("pull-up state mismatch");
  pulldown_rd_a: assert property (
    rd_of(ADDR_PULLDOWN_STATE) |=> bus_rdata == ~$past(pad.pulldown_en))
    else $error("pull-down state mismatch");
  sel_back_a: assert property (
    sel_wr_rd |=> bus_rdata == $past(bus_req.wdata, 2)) else $error("select readback wrong");
endmodule

bind ilc_io_line_controller ilc_io_line_controller_chk #(.MUXED_LINES(MUXED_LINES)) chk_i (
  .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .periph_pin_in(periph_pin_in), .pin_in(pin_in), .pad(pad));

`default_nettype wire

// ==== test/ilc_pad_partner.sv ====
`default_nettype none

module ilc_pad_partner
  import ilc_pkg::*;
(
  input wire logic sys_clk,
  input wire ilc_pad_type pad,
  output ilc_periph_type [ILC_PERIPHS-1:0] periph_drive,
  output logic [ILC_LINES-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  always @(posedge sys_clk) flip <= ~flip;
  // Peripheral k drives line 4+k high only, so a wrong select shows as a low line.
  // A floating line with no pull toggles each cycle.
  always_comb
  begin
    for (int k = 0; k < ILC_PERIPHS; k++)
    begin
      periph_drive[k].out = 32'h0000_0010 << k;
      periph_drive[k].oe = 32'hFFFF_FFFF;
    end
    for (int i = 0; i < ILC_LINES; i++)
    begin
      pin_in[i] = pad.oe[i] ? pad.out[i]
        : pad.pullup_en[i] ? 1'b1
        : pad.pulldown_en[i] ? 1'b0
        : flip;
    end
  end
endmodule

`default_nettype wire

// ==== test/test_ilc_io_line_controller.sv ====
`default_nettype none

module test_ilc_io_line_controller
  import ilc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ilc_bus_req_type bus_req = '0;
  logic [31:0] bus_rdata;
  ilc_periph_type [ILC_PERIPHS-1:0] periph_drive;
  logic [31:0] periph_pin_in;
  logic [ILC_LINES-1:0] pin_in;
  ilc_pad_type pad;
  int n_mismatch = 0;
  int comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  ilc_io_line_controller #(.MUXED_LINES(32'h7FFF_FFFF)) ilc_io_line_controller_i (
    .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .periph_drive(periph_drive), .periph_pin_in(periph_pin_in), .pin_in(pin_in), .pad(pad));
  ilc_pad_partner ilc_pad_partner_i (
    .sys_clk(sys_clk), .pad(pad), .periph_drive(periph_drive), .pin_in(pin_in));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
  endtask
  task r(input logic [7:0] a, input logic [31:0] e);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(bus_rdata, e);
  endtask
  task idle;
    bus_req <= '0;
    @(posedge sys_clk);
    #1;
  endtask
  task test_done;
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    r(ADDR_OWNER_STATE, 32'hFFFF_FFFF);
    r(ADDR_PULLUP_STATE, 32'h0000_0000);
    r(ADDR_PULLDOWN_STATE, 32'hFFFF_FFFF);
    r(ADDR_PERIPH_SELECT_HI, 32'h0000_0000);
    r(ADDR_DIRECT_WRITE_MASK, 32'h0000_0000);
    r(ADDR_OPEN_DRAIN_STATE, 32'h0000_0000);
    w(ADDR_PULLDOWN_ON_WR, 32'h0000_0003);
    r(ADDR_PULLDOWN_STATE, 32'hFFFF_FFFF);
    w(ADDR_PULLUP_OFF_WR, 32'h0000_0001);
    w(ADDR_PULLDOWN_ON_WR, 32'h0000_0003);
    r(ADDR_PULLDOWN_STATE, 32'hFFFF_FFFE);
    w(ADDR_PULLUP_ON_WR, 32'h0000_0001);
    r(ADDR_PULLUP_STATE, 32'h0000_0001);
    idle;
    chk(pad.pulldown_en, 32'h0000_0001);
    chk(pad.pullup_en, 32'hFFFF_FFFE);
    w(ADDR_DRIVE_ON_WR, 32'h0000_000F);
    w(ADDR_LEVEL_SET_WR, 32'h0000_0005);
    idle;
    chk(pad.oe, 32'h0000_000F);
    chk(pad.out & 32'h0000_000F, 32'h0000_0005);
    w(ADDR_DIRECT_WRITE_ON_WR, 32'h0000_0003);
    w(ADDR_LEVEL_STATE, 32'hFFFF_FFFA);
    r(ADDR_LEVEL_STATE, 32'h0000_0006);
    w(ADDR_PERIPH_SELECT_LO, 32'h0000_00A0);
    r(ADDR_PERIPH_SELECT_LO, 32'h0000_00A0);
    w(ADDR_PERIPH_SELECT_HI, 32'h0000_00C0);
    idle;
    chk(pad.oe & 32'h0000_00F0, 32'h0000_0000);
    w(ADDR_OWNER_PERIPH_SET_WR, 32'h8000_00F0);
    r(ADDR_OWNER_STATE, 32'hFFFF_FF0F);
    idle;
    chk(pad.oe & 32'h0000_00F0, 32'h0000_00F0);
    chk(pad.out & 32'h0000_00F0, 32'h0000_00F0);
    w(ADDR_DRIVE_ON_WR, 32'h0000_0010);
    r(ADDR_DRIVE_STATE, 32'h0000_001F);
    w(ADDR_OPEN_DRAIN_ON_WR, 32'h0000_0013);
    idle;
    chk(pad.oe & 32'h0000_0013, 32'h0000_0001);
    chk(pad.out & 32'h0000_0001, 32'h0000_0000);
    idle;
    idle;
    chk(periph_pin_in, pin_in);
    w(ADDR_OWNER_CTRL_SET_WR, 32'h0000_00F0);
    r(ADDR_OWNER_STATE, 32'hFFFF_FFFF);
    r(8'hFC, 32'h0000_0000);
    idle;
    test_done;
  end
endmodule

`default_nettype wire
